/* File: rtl/twhs_pkg.sv */
// Overview of operation
// - Interrupt line is high while done flag, local enable and global enable are set.
// - Every finished bus step except a stop condition sets the done flag.
// - Writing one to the done bit of the control register clears the flag.
// - No bus step starts while the flag is set; it starts once cleared.
// - Serial clock is held low while the done flag is set.
// - After the start condition the flag sets and status reports start sent.
// - One data register carries address and data; software loads it first.
// - After the address byte the flag sets; status shows slave acknowledge.
// - After a data byte the flag sets; status shows slave acknowledge.
// - No done flag is raised once a stop condition has been sent.
// - A clearing control write carries out the operation its bits request.
// - Status takes the event code one cycle after the flag rises.
// - Without the flag, status shows the no-information code.
// - Lost arbitration and illegal start or stop on the bus set the flag.
package twhs_pkg;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SCL_HALF_NS = 40;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] ACK_BIT = 4'h8;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_DATA = 8'h08;

  localparam int unsigned CTRL_DONE = 7;
  localparam int unsigned CTRL_STA = 5;
  localparam int unsigned CTRL_STO = 4;
  localparam int unsigned CTRL_EN = 2;
  localparam int unsigned CTRL_IE = 0;

  localparam logic [7:0] STAT_MASK = 8'hF8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_ADR_ACK = 8'h18;
  localparam logic [7:0] ST_ADR_NACK = 8'h20;
  localparam logic [7:0] ST_DAT_ACK = 8'h28;
  localparam logic [7:0] ST_DAT_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;
  localparam logic [7:0] ST_BUS_ERR = 8'h00;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_HOLD = 4'h1,
    ST_STA1 = 4'h2,
    ST_STA2 = 4'h3,
    ST_STA3 = 4'h4,
    ST_LOW = 4'h5,
    ST_HIGH = 4'h6,
    ST_STP1 = 4'h7,
    ST_STP2 = 4'h8,
    ST_STP3 = 4'h9
  } twhs_state_e;

  typedef struct packed {
    logic sta;
    logic sto;
    logic en;
    logic ie;
  } twhs_ctrl_s;

endpackage

/* File: rtl/twhs_sync.sv */
`timescale 1ns/1ps
module twhs_sync #(
  parameter int unsigned W = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages per bit; only the second stage is read
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        meta_q[i] <= 1'b1;
        sync_q[i] <= 1'b1;
      end else begin
        meta_q[i] <= din[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign dout = sync_q;

endmodule

/* File: rtl/twhs_top.sv */
`timescale 1ns/1ps
module twhs_top #(
  parameter int unsigned HALF_CYC = twhs_pkg::SCL_HALF_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic cpu_irq_en,
  output logic irq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic sda_p_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic acc;
  logic wr_ctrl;
  logic wr_data;
  logic go;
  logic go_q;
  twhs_pkg::twhs_ctrl_s ctrl_q;
  logic [7:0] data_q;
  logic done_q;
  logic [7:0] code_q;
  logic [7:0] stat_q;
  logic irq_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic pin_lo_q;
  twhs_pkg::twhs_state_e state_q;
  logic [15:0] cnt_q;
  logic tick;
  logic [3:0] bit_q;
  logic [7:0] shr_q;
  logic addr_q;
  logic rst_q;
  logic berr;
  logic e_arb;
  logic e_start;
  logic e_byte;
  logic evt;
  logic [7:0] evt_code;
  logic scl_lo;
  logic sda_lo;
  logic [7:0] ctrl_rd;

  twhs_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({scl_i, sda_i}),
    .dout(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_p_q <= 1'b1;
    end else begin
      sda_p_q <= sda_s;
    end
  end

  // Wishbone classic slave, one wait state, ack for one cycle
  assign acc = wb_cyc && wb_stb && !ack_q;
  assign wr_ctrl = acc && wb_we && wb_sel[0] && wb_adr == twhs_pkg::ADR_CTRL;
  assign wr_data = acc && wb_we && wb_sel[0] && wb_adr == twhs_pkg::ADR_DATA;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[twhs_pkg::CTRL_DONE] = done_q;
    ctrl_rd[twhs_pkg::CTRL_STA] = ctrl_q.sta;
    ctrl_rd[twhs_pkg::CTRL_STO] = ctrl_q.sto;
    ctrl_rd[twhs_pkg::CTRL_EN] = ctrl_q.en;
    ctrl_rd[twhs_pkg::CTRL_IE] = ctrl_q.ie;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdat_q <= twhs_pkg::RD_ZERO;
    end else if (acc && !wb_we) begin
      case (wb_adr)
        twhs_pkg::ADR_CTRL: rdat_q <= {24'h00_0000, ctrl_rd};
        twhs_pkg::ADR_STAT: rdat_q <= {24'h00_0000, stat_q};
        twhs_pkg::ADR_DATA: rdat_q <= {24'h00_0000, data_q};
        default: rdat_q <= twhs_pkg::RD_ZERO;
      endcase
    end
  end

  // Control bits; stop request drops when the stop has been sent
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q.sta <= wb_dat_w[twhs_pkg::CTRL_STA];
      ctrl_q.sto <= wb_dat_w[twhs_pkg::CTRL_STO];
      ctrl_q.en <= wb_dat_w[twhs_pkg::CTRL_EN];
      ctrl_q.ie <= wb_dat_w[twhs_pkg::CTRL_IE];
    end else if (state_q == twhs_pkg::ST_STP3 && tick) begin
      ctrl_q.sto <= 1'b0;
    end
  end

  // Address and data share one register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= 8'h00;
    end else if (wr_data) begin
      data_q <= wb_dat_w[7:0];
    end
  end

  // A clearing write launches the step one cycle later
  assign go = wr_ctrl && wb_dat_w[twhs_pkg::CTRL_DONE] && !evt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go;
    end
  end

  // Half period timer; high phase waits while a slave stretches the clock
  assign tick = cnt_q == 16'(HALF_CYC - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
    end else if (tick || state_q == twhs_pkg::ST_IDLE ||
                 state_q == twhs_pkg::ST_HOLD ||
                 (state_q == twhs_pkg::ST_HIGH && !scl_s)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Bus events
  assign berr = state_q == twhs_pkg::ST_HIGH && scl_s &&
                sda_s != sda_p_q;
  assign e_arb = state_q == twhs_pkg::ST_HIGH && tick && !berr &&
                 bit_q != twhs_pkg::ACK_BIT && shr_q[7] && !sda_s;
  assign e_start = state_q == twhs_pkg::ST_STA3 && tick;
  assign e_byte = state_q == twhs_pkg::ST_HIGH && tick && !berr &&
                  bit_q == twhs_pkg::ACK_BIT;
  assign evt = berr || e_arb || e_start || e_byte;

  always_comb begin
    evt_code = twhs_pkg::ST_NO_INFO;
    if (berr) begin
      evt_code = twhs_pkg::ST_BUS_ERR;
    end else if (e_arb) begin
      evt_code = twhs_pkg::ST_ARB_LOST;
    end else if (e_start) begin
      evt_code = rst_q ? twhs_pkg::ST_RSTART : twhs_pkg::ST_START;
    end else if (e_byte && addr_q) begin
      evt_code = sda_s ? twhs_pkg::ST_ADR_NACK : twhs_pkg::ST_ADR_ACK;
    end else if (e_byte) begin
      evt_code = sda_s ? twhs_pkg::ST_DAT_NACK : twhs_pkg::ST_DAT_ACK;
    end
  end

  // Done flag: hardware sets, a one written clears, the set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else if (evt) begin
      done_q <= 1'b1;
    end else if (wr_ctrl && wb_dat_w[twhs_pkg::CTRL_DONE]) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= twhs_pkg::ST_NO_INFO;
    end else if (evt) begin
      code_q <= evt_code;
    end
  end

  // Status lags the flag by one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= twhs_pkg::ST_NO_INFO;
    end else if (done_q) begin
      stat_q <= code_q;
    end else begin
      stat_q <= twhs_pkg::ST_NO_INFO;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= done_q && ctrl_q.ie && cpu_irq_en;
    end
  end

  // Bit engine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= twhs_pkg::ST_IDLE;
      bit_q <= 4'h0;
      shr_q <= 8'h00;
      addr_q <= 1'b0;
      rst_q <= 1'b0;
    end else if (!ctrl_q.en) begin
      state_q <= twhs_pkg::ST_IDLE;
    end else begin
      case (state_q)
        twhs_pkg::ST_IDLE: begin
          if (go_q && ctrl_q.sta) begin
            state_q <= twhs_pkg::ST_STA1;
            rst_q <= 1'b0;
          end
        end
        twhs_pkg::ST_HOLD: begin
          if (go_q && ctrl_q.sta) begin
            state_q <= twhs_pkg::ST_STA1;
            rst_q <= 1'b1;
          end else if (go_q && ctrl_q.sto) begin
            state_q <= twhs_pkg::ST_STP1;
          end else if (go_q) begin
            state_q <= twhs_pkg::ST_LOW;
            shr_q <= data_q;
            bit_q <= 4'h0;
          end
        end
        twhs_pkg::ST_STA1: begin
          if (tick) begin
            state_q <= twhs_pkg::ST_STA2;
          end
        end
        twhs_pkg::ST_STA2: begin
          if (tick) begin
            state_q <= twhs_pkg::ST_STA3;
          end
        end
        twhs_pkg::ST_STA3: begin
          if (tick) begin
            state_q <= twhs_pkg::ST_HOLD;
            addr_q <= 1'b1;
          end
        end
        twhs_pkg::ST_LOW: begin
          if (tick) begin
            state_q <= twhs_pkg::ST_HIGH;
          end
        end
        twhs_pkg::ST_HIGH: begin
          if (berr || e_arb) begin
            state_q <= twhs_pkg::ST_IDLE;
          end else if (e_byte) begin
            state_q <= twhs_pkg::ST_HOLD;
            addr_q <= 1'b0;
          end else if (tick) begin
            state_q <= twhs_pkg::ST_LOW;
            shr_q <= {shr_q[6:0], 1'b0};
            bit_q <= bit_q + 4'h1;
          end
        end
        twhs_pkg::ST_STP1: begin
          if (tick) begin
            state_q <= twhs_pkg::ST_STP2;
          end
        end
        twhs_pkg::ST_STP2: begin
          if (tick) begin
            state_q <= twhs_pkg::ST_STP3;
          end
        end
        twhs_pkg::ST_STP3: begin
          if (tick) begin
            state_q <= twhs_pkg::ST_IDLE;
          end
        end
        default: state_q <= twhs_pkg::ST_IDLE;
      endcase
    end
  end

  // Open-drain drive; clock stays low while the flag is up
  assign scl_lo = done_q || state_q == twhs_pkg::ST_HOLD ||
                  state_q == twhs_pkg::ST_STA3 ||
                  state_q == twhs_pkg::ST_LOW ||
                  state_q == twhs_pkg::ST_STP1;
  assign sda_lo = state_q == twhs_pkg::ST_STA2 ||
                  state_q == twhs_pkg::ST_STA3 ||
                  state_q == twhs_pkg::ST_STP1 ||
                  state_q == twhs_pkg::ST_STP2 ||
                  (state_q == twhs_pkg::ST_HOLD && addr_q) ||
                  ((state_q == twhs_pkg::ST_LOW ||
                    state_q == twhs_pkg::ST_HIGH) &&
                   bit_q != twhs_pkg::ACK_BIT && !shr_q[7]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      pin_lo_q <= 1'b0;
    end else begin
      scl_oe_q <= scl_lo;
      sda_oe_q <= sda_lo;
      pin_lo_q <= 1'b0;
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = rdat_q;
  assign irq = irq_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign scl_o = pin_lo_q;
  assign sda_o = pin_lo_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  irq_gate_a: assert property (
    done_q && ctrl_q.ie && cpu_irq_en |=> irq)
    else $error("irq not raised for enabled done flag");
  flag_set_a: assert property (
    evt |=> done_q ##1 stat_q == $past(code_q))
    else $error("event did not set flag and status");
  flag_clr_a: assert property (
    wr_ctrl && wb_dat_w[twhs_pkg::CTRL_DONE] && !evt |=> !done_q)
    else $error("writing one did not clear flag");
  hold_still_a: assert property (
    done_q |-> state_q == twhs_pkg::ST_IDLE || state_q == twhs_pkg::ST_HOLD)
    else $error("engine ran while flag set");
  go_stop_a: assert property (
    go_q && ctrl_q.en && state_q == twhs_pkg::ST_HOLD && ctrl_q.sto &&
    !ctrl_q.sta |=> state_q == twhs_pkg::ST_STP1)
    else $error("stop request not carried out");
  scl_low_a: assert property (
    done_q [*2] |-> scl_oe)
    else $error("clock released while flag set");
  start_code_a: assert property (
    e_start && !rst_q |=> done_q ##1 stat_q == twhs_pkg::ST_START)
    else $error("start status missing");
  adr_code_a: assert property (
    e_byte && addr_q && !sda_s |=> ##1 stat_q == twhs_pkg::ST_ADR_ACK)
    else $error("address ack status missing");
  dat_code_a: assert property (
    e_byte && !addr_q && sda_s |=> ##1 stat_q == twhs_pkg::ST_DAT_NACK)
    else $error("data nack status missing");
  stop_flag_a: assert property (
    state_q == twhs_pkg::ST_STP3 && tick && !done_q |=> !done_q)
    else $error("flag set after stop");
  no_info_a: assert property (
    $fell(done_q) |=> stat_q == twhs_pkg::ST_NO_INFO)
    else $error("status not idle after flag cleared");
  berr_idle_a: assert property (
    berr |=> done_q && state_q == twhs_pkg::ST_IDLE)
    else $error("bus error not flagged");
  zero_wr_a: assert property (
    wr_ctrl && !wb_dat_w[twhs_pkg::CTRL_DONE] && !evt |=> $stable(done_q))
    else $error("zero write changed flag");

  start_cov_c: cover property (e_start);
  byte_cov_c: cover property (e_byte && !addr_q && !sda_s);
  stop_cov_c: cover property (state_q == twhs_pkg::ST_STP3 && tick);

endmodule

/* File: tb/twhs_slave.sv */
`timescale 1ns/1ps
module twhs_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic stretch,
  output logic sda_pull,
  output logic scl_pull,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  int bits;
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
    bits = 0;
  end
  // Start condition restarts the bit count
  always @(negedge sda) begin
    if (scl) begin
      bits = 0;
    end
  end
  // Shift in on rising clock, MSB first
  always @(posedge scl) begin
    if (bits < 8) begin
      sh = {sh[6:0], sda};
    end
    bits = bits + 1;
    if (bits == 8) begin
      rx_byte = sh;
    end
  end
  // Acknowledge slot, and optional clock stretch on every low phase
  always @(negedge scl) begin
    if (bits == 8) begin
      sda_pull = !nack;
    end else if (bits >= 9) begin
      sda_pull = 1'b0;
      bits = 0;
    end
    if (stretch) begin
      scl_pull = 1'b1;
      #205;
      scl_pull = 1'b0;
    end
  end
endmodule

/* File: tb/twhs_tb_top.sv */
`timescale 1ns/1ps
module twhs_tb_top;
  localparam logic [7:0] CT = twhs_pkg::ADR_CTRL;
  localparam logic [7:0] SR = twhs_pkg::ADR_STAT;
  localparam logic [7:0] DR = twhs_pkg::ADR_DATA;
  localparam logic [7:0] MK = twhs_pkg::STAT_MASK;
  logic clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, cpu_irq_en, irq;
  logic [7:0] wb_adr, rx_byte;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic scl_o, scl_oe, sda_o, sda_oe, nack, stretch, tb_pull;
  logic s_sda, s_scl, scl_w, sda_w;
  int err_count, checks_done;

  // Open-drain lines with pull-ups
  assign scl_w = !((scl_oe && !scl_o) || s_scl);
  assign sda_w = !((sda_oe && !sda_o) || s_sda || tb_pull);

  twhs_top #(.HALF_CYC(4)) dut (.clk(clk), .arst_n(arst_n),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .cpu_irq_en(cpu_irq_en), .irq(irq), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe));

  twhs_slave slave (.scl(scl_w), .sda(sda_w), .nack(nack),
    .stretch(stretch), .sda_pull(s_sda), .scl_pull(s_scl),
    .rx_byte(rx_byte));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= {24'h00_0000, d};
    do @(posedge clk); while (wb_ack !== 1'b1);
    q = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask

  // Poll the done flag with a bounded count
  task automatic wflag();
    logic [7:0] q;
    int n;
    q = 8'h00;
    n = 0;
    while (q[7] !== 1'b1 && n < 600) begin
      wb(1'b0, CT, 8'h00, q);
      n++;
    end
    chk(8'(q[7]), 8'h01);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    err_count = 0;
    checks_done = 0;
    arst_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, cpu_irq_en, nack, stretch, tb_pull} = 7'h00;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0000_0000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(CT, 8'hff, 8'h00);
    rd(SR, 8'hff, twhs_pkg::ST_NO_INFO);
    rd(DR, 8'hff, 8'h00);
    rd(8'h0c, 8'hff, 8'h00);
    wr(CT, 8'h24);
    repeat (40) @(posedge clk);
    rd(SR, MK, twhs_pkg::ST_NO_INFO);
    chk(8'(scl_w), 8'h01);
    cpu_irq_en <= 1'b1;
    wr(CT, 8'ha5);
    wflag();
    rd(SR, MK, twhs_pkg::ST_START);
    chk(8'(irq), 8'h01);
    repeat (50) @(posedge clk);
    chk(8'(scl_w), 8'h00);
    cpu_irq_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk(8'(irq), 8'h00);
    wr(CT, 8'h05);
    rd(CT, 8'h80, 8'h80);
    rd(SR, MK, twhs_pkg::ST_START);
    wr(DR, 8'ha0);
    wr(CT, 8'h85);
    rd(CT, 8'h80, 8'h00);
    wflag();
    rd(SR, MK, twhs_pkg::ST_ADR_ACK);
    chk(rx_byte, 8'ha0);
    nack <= 1'b1;
    stretch <= 1'b1;
    wr(DR, 8'h3c);
    wr(CT, 8'h85);
    wflag();
    rd(SR, MK, twhs_pkg::ST_DAT_NACK);
    chk(rx_byte, 8'h3c);
    nack <= 1'b0;
    stretch <= 1'b0;
    wr(DR, 8'hc3);
    wr(CT, 8'h85);
    wflag();
    rd(SR, MK, twhs_pkg::ST_DAT_ACK);
    chk(rx_byte, 8'hc3);
    wr(CT, 8'h94);
    repeat (200) @(posedge clk);
    rd(CT, 8'h80, 8'h00);
    rd(SR, MK, twhs_pkg::ST_NO_INFO);
    chk({6'h00, scl_w, sda_w}, 8'h03);
    // Lost arbitration: a released data bit is held low from outside
    wr(CT, 8'ha4);
    wflag();
    wr(DR, 8'hff);
    wr(CT, 8'h84);
    tb_pull <= 1'b1;
    wflag();
    rd(SR, MK, twhs_pkg::ST_ARB_LOST);
    tb_pull <= 1'b0;
    chk(8'(scl_w), 8'h00);
    wr(CT, 8'h84);
    rd(SR, MK, twhs_pkg::ST_NO_INFO);
    // Bus error: data line falls while the clock is high
    wr(CT, 8'ha4);
    wflag();
    wr(DR, 8'hff);
    wr(CT, 8'h84);
    @(posedge scl_w);
    @(posedge clk);
    tb_pull <= 1'b1;
    wflag();
    rd(SR, MK, twhs_pkg::ST_BUS_ERR);
    tb_pull <= 1'b0;
    wr(CT, 8'h84);
    // Address refused by the slave
    wr(CT, 8'ha4);
    wflag();
    nack <= 1'b1;
    wr(DR, 8'h5a);
    wr(CT, 8'h85);
    wflag();
    rd(SR, MK, twhs_pkg::ST_ADR_NACK);
    chk(rx_byte, 8'h5a);
    // Repeated start straight from the hold state
    wr(CT, 8'ha4);
    wflag();
    rd(SR, MK, twhs_pkg::ST_RSTART);
    wr(CT, 8'h94);
    repeat (100) @(posedge clk);
    rd(CT, 8'h80, 8'h00);
    summarize();
  end
endmodule
